// ---- src/mmd_control.sv ----
`timescale 1ns/10ps
module mmd_control
	import mmd_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// function selects
	input wire logic probe_select_i,
	input wire logic measure_select_i,
	input wire logic range_or_count_input_i,
	// point / probe inputs
	input wire logic point0_low_input_i,
	input wire logic point1_high_input_i,
	input wire logic sounder_request_i,
	// comparator from analog integrator: high while charge remains
	input wire logic integ_positive_i,
	// done/freeze pin
	input wire logic freeze_i,
	output logic done_o,
	output logic done_oe_o,
	// display
	output logic [CNT_W-1:0] display_value_o,
	output logic [1:0] display_point_o,
	output logic points_off_o,
	output logic overload_text_o,
	output logic high_annunciator_o,
	output logic low_annunciator_o,
	output logic buzzer_o,
	// analog and pad control
	output logic autozero_o,
	output logic integrate_o,
	output logic deintegrate_o,
	output logic point_pulldown_en_o,
	// range flags
	output logic over_range_o,
	output logic under_limit_flag_o
);
	logic [6:0] sync_in;
	logic probe_s, meas_s, range_s, p0_s, p1_s, snd_s, frz_s;
	mmd_sync #(.W(7)) u_sync (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.async_i({probe_select_i, measure_select_i, range_or_count_input_i, point0_low_input_i,
			point1_high_input_i, sounder_request_i, freeze_i}),
		.sync_o(sync_in)
	); // [RL19]
	assign {probe_s, meas_s, range_s, p0_s, p1_s, snd_s, frz_s} = sync_in;

	function automatic logic [CNT_W-1:0] inc_sat(input logic [CNT_W-1:0] v);
		inc_sat = (v == '1) ? v : v + 16'h0001;
	endfunction

	mmd_mode_t mode_q, mode_d;
	mmd_phase_t phase_q, phase_d;
	logic meas_prev_q, meas_prev_d;
	logic div2_q, div2_d;
	logic [CNT_W-1:0] tick_q, tick_d;
	logic [CNT_W-1:0] count_q, count_d;
	logic [CNT_W-1:0] result_q, result_d;
	logic [CNT_W-1:0] disp_q, disp_d;
	logic [3:0] done_cnt_q, done_cnt_d;
	logic range_prev_q, range_prev_d;
	logic [1:0] point_q, point_d;
	logic over_q, over_d, under_q, under_d;
	logic done_q, done_d, doe_q, doe_d;
	logic az_q, az_d, int_q, int_d, deint_q, deint_d;
	logic hi_q, hi_d, lo_q, lo_d, ol_q, ol_d, poff_q, poff_d, pd_q, pd_d;
	logic buz_req;
	logic new_mode;
	logic conv_end;

	always_comb begin
		// selects decode
		if (probe_s) begin
			mode_d = MMD_MODE_PROBE; // [RL1]
		end else if (meas_s) begin
			mode_d = MMD_MODE_FREQ;
		end else begin
			mode_d = MMD_MODE_ADC; // [RL4]
		end
	end

	always_comb begin
		div2_d = ~div2_q;
		meas_prev_d = meas_s;
		range_prev_d = range_s;
		phase_d = phase_q;
		tick_d = tick_q;
		count_d = count_q;
		result_d = result_q;
		done_cnt_d = done_cnt_q;
		conv_end = 1'b0;
		// frequency mode survives probe entry, so only a measure select change or a probe exit with measure low counts
		new_mode = (meas_s != meas_prev_q) || (mode_q == MMD_MODE_PROBE && mode_d != MMD_MODE_PROBE && !meas_s);
		if (new_mode) begin
			phase_d = MMD_PH_AZ; // [RL20]
			tick_d = '0;
			count_d = '0;
		end else if (meas_s) begin
			// counting runs even in probe mode [RL17]
			if (range_s && !range_prev_q) begin
				count_d = inc_sat(count_q); // [RL3]
			end
			if (tick_q == GATE_CYCLES - 16'h0001) begin
				tick_d = '0;
				result_d = count_d;
				count_d = '0;
				conv_end = 1'b1;
			end else begin
				tick_d = tick_q + 16'h0001; // [RL3]
			end
		end else if (probe_s) begin
			phase_d = MMD_PH_AZ; // [RL16]
			tick_d = '0;
		end else if (div2_q) begin
			// converter sequencer on divided clock [RL18]
			case (phase_q)
				MMD_PH_AZ: begin
					if (tick_q == AZ_COUNTS - 16'h0001) begin
						tick_d = '0;
						phase_d = MMD_PH_INT;
					end else begin
						tick_d = tick_q + 16'h0001;
					end
				end
				MMD_PH_INT: begin
					if (tick_q == (range_s ? INT_COUNTS_HI : INT_COUNTS_LO) - 16'h0001) begin // [RL2]
						tick_d = '0;
						phase_d = MMD_PH_DEINT;
					end else begin
						tick_d = tick_q + 16'h0001;
					end
				end
				MMD_PH_DEINT: begin
					if (!integ_positive_i || tick_q == DEINT_MAX) begin
						result_d = tick_q;
						tick_d = '0;
						phase_d = MMD_PH_AZ;
						conv_end = 1'b1;
					end else begin
						tick_d = tick_q + 16'h0001;
					end
				end
				default: begin
					phase_d = MMD_PH_AZ;
					tick_d = '0;
				end
			endcase
		end
		if (conv_end) begin
			done_cnt_d = DONE_CYCLES; // [RL11]
		end else if (done_cnt_q != 4'h0) begin
			done_cnt_d = done_cnt_q - 4'h1;
		end
	end

	always_comb begin
		disp_d = disp_q;
		// display takes the new result at pulse start unless frozen
		if (conv_end && !frz_s) begin
			disp_d = result_d; // [RL11] [RL12]
		end
		done_d = !(conv_end || done_cnt_q > 4'h1); // [RL11]
		doe_d = !done_d;
		over_d = over_q;
		under_d = under_q;
		if (conv_end) begin
			over_d = result_d > FULL_SCALE; // [RL13]
			under_d = result_d <= UNDER_LIMIT; // [RL14]
		end
		az_d = (phase_d == MMD_PH_AZ) && !meas_s; // [RL16]
		int_d = (phase_d == MMD_PH_INT) && !meas_s && !probe_s;
		deint_d = (phase_d == MMD_PH_DEINT) && !meas_s && !probe_s;
		point_d = {p1_s, p0_s}; // [RL6]
		ol_d = probe_s; // [RL5]
		poff_d = probe_s && !meas_s; // [RL5] [RL17]
		hi_d = probe_s && p1_s; // [RL7]
		lo_d = probe_s && p0_s; // [RL8]
		pd_d = !probe_s; // [RL9]
	end
	assign buz_req = snd_s || (probe_s && p0_s); // [RL8] [RL10]

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mode_q <= MMD_MODE_ADC;
			phase_q <= MMD_PH_AZ;
			meas_prev_q <= 1'b0;
			range_prev_q <= 1'b0;
			div2_q <= 1'b0;
			tick_q <= '0;
			count_q <= '0;
			result_q <= '0;
			disp_q <= '0;
			done_cnt_q <= '0;
			done_q <= 1'b1;
			doe_q <= 1'b0;
			over_q <= 1'b0;
			under_q <= 1'b0;
			az_q <= 1'b1;
			int_q <= 1'b0;
			deint_q <= 1'b0;
			point_q <= MMD_DP_NONE;
			ol_q <= 1'b0;
			poff_q <= 1'b0;
			hi_q <= 1'b0;
			lo_q <= 1'b0;
			pd_q <= 1'b1;
		end else begin
			mode_q <= mode_d;
			phase_q <= phase_d;
			meas_prev_q <= meas_prev_d;
			range_prev_q <= range_prev_d;
			div2_q <= div2_d;
			tick_q <= tick_d;
			count_q <= count_d;
			result_q <= result_d;
			disp_q <= disp_d;
			done_cnt_q <= done_cnt_d;
			done_q <= done_d;
			doe_q <= doe_d;
			over_q <= over_d;
			under_q <= under_d;
			az_q <= az_d;
			int_q <= int_d;
			deint_q <= deint_d;
			point_q <= point_d;
			ol_q <= ol_d;
			poff_q <= poff_d;
			hi_q <= hi_d;
			lo_q <= lo_d;
			pd_q <= pd_d;
		end
	end

	mmd_buzzer u_buzzer (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.enable_i(buz_req),
		.buzzer_o(buzzer_o)
	);

	assign done_o = done_q;
	assign done_oe_o = doe_q;
	assign display_value_o = disp_q;
	assign display_point_o = point_q;
	assign points_off_o = poff_q;
	assign overload_text_o = ol_q;
	assign high_annunciator_o = hi_q;
	assign low_annunciator_o = lo_q;
	assign autozero_o = az_q;
	assign integrate_o = int_q;
	assign deintegrate_o = deint_q;
	assign point_pulldown_en_o = pd_q;
	assign over_range_o = over_q;
	assign under_limit_flag_o = under_q;
endmodule

// ---- inc/mmd_pkg.sv ----
// Functional notes
// [RL1] probe select high forces probe mode
// [RL2] convert mode; range input shortens integrate tenfold
// [RL3] count mode gate is 40000 oscillator periods
// [RL4] undriven selects mean converter mode
// [RL5] probe mode: overload text, points off
// [RL6] two point inputs choose display point
// [RL7] probe: upper point input lights high
// [RL8] probe: lower point input lights low, buzzer
// [RL9] point pull-downs only outside probe mode
// [RL10] sounder request turns buzzer on always
// [RL11] done pin low ten cycles per conversion
// [RL12] freeze high holds display, conversion continues
// [RL13] over-range when count exceeds 3999
// [RL14] under-range when reading at most 380
// [RL15] outside party ANDs flags with inverted done
// [RL16] probe during convert holds auto-zero phase
// [RL17] probe during count keeps counter, points shown
// [RL18] buzzer clock /8, converter counters clock /2
// [RL19] synchronise all pin inputs first; integ_positive_i is used without synchronising
// [RL20] mode change restarts conversion or gate
package mmd_pkg;
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] FULL_SCALE = 16'h0F9F;     // 3999
	localparam logic [CNT_W-1:0] UNDER_LIMIT = 16'h017C;    // 380
	localparam logic [CNT_W-1:0] AZ_COUNTS = 16'h07D0;      // 2000 auto-zero ticks
	localparam logic [CNT_W-1:0] INT_COUNTS_LO = 16'h07D0;  // 2000 integrate ticks
	localparam logic [CNT_W-1:0] INT_COUNTS_HI = 16'h00C8;  // 200, tenfold shorter
	localparam logic [CNT_W-1:0] DEINT_MAX = 16'h0FA0;      // 4000 ticks cap
	localparam logic [CNT_W-1:0] GATE_CYCLES = 16'h9C40;    // 40000 osc periods
	localparam logic [3:0] DONE_CYCLES = 4'hA;
	localparam logic [2:0] BUZ_DIV_HALF = 3'h3;             // toggle every 4 -> /8
	typedef enum logic [2:0] {
		MMD_MODE_ADC = 3'b001,
		MMD_MODE_FREQ = 3'b010,
		MMD_MODE_PROBE = 3'b100
	} mmd_mode_t;
	typedef enum logic [3:0] {
		MMD_PH_AZ = 4'b0001,
		MMD_PH_INT = 4'b0010,
		MMD_PH_DEINT = 4'b0100,
		MMD_PH_DONE = 4'b1000
	} mmd_phase_t;
	typedef enum logic [1:0] {
		MMD_DP_NONE = 2'h0,
		MMD_DP_ONE = 2'h1,
		MMD_DP_TWO = 2'h2,
		MMD_DP_THREE = 2'h3
	} mmd_point_t;
endpackage

// ---- src/mmd_sync.sv ----
`timescale 1ns/10ps
module mmd_sync #(
	parameter int W = 1
) (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;
	always_comb begin
		meta_d = async_i;
		sync_d = meta_q;
	end
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end
	assign sync_o = sync_q;
endmodule

// ---- src/mmd_buzzer.sv ----
`timescale 1ns/10ps
module mmd_buzzer
	import mmd_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic enable_i,
	output logic buzzer_o
);
	logic [2:0] div_q;
	logic [2:0] div_d;
	logic tone_q;
	logic tone_d;
	always_comb begin
		div_d = div_q;
		tone_d = tone_q;
		if (!enable_i) begin
			div_d = '0;
			tone_d = 1'b0;
		end else if (div_q == BUZ_DIV_HALF) begin
			div_d = '0;
			tone_d = ~tone_q; // [RL18]
		end else begin
			div_d = div_q + 3'h1;
		end
	end
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			div_q <= '0;
			tone_q <= 1'b0;
		end else begin
			div_q <= div_d;
			tone_q <= tone_d;
		end
	end
	assign buzzer_o = tone_q;
endmodule

// ---- tb/mmd_front_model.sv ----
`timescale 1ns/10ps
module mmd_front_model (
	// clock
	input wire logic sys_clk_i,
	// from the block
	input wire logic deint_i,
	input wire logic done_oe_i,
	// bench controls
	input wire logic [15:0] ticks_i,
	input wire logic hold_i,
	// to the block
	output logic integ_o,
	output logic freeze_o
);
	logic [15:0] n_q;
	always_ff @(posedge sys_clk_i) begin
		n_q <= deint_i ? n_q + 16'h0001 : 16'h0000;
	end
	// charge left for ticks_i clocks; all ones never discharges
	assign integ_o = deint_i && (ticks_i == 16'hFFFF || n_q < ticks_i);
	// pin pulled low by the block, else held by the outside party
	assign freeze_o = done_oe_i ? 1'h0 : hold_i;
endmodule

// ---- tb/mmd_control_properties.sv ----
`timescale 1ns/10ps
module mmd_control_properties
	import mmd_pkg::*;
(
	// clock, reset and pins
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic probe_select_i,
	input wire logic measure_select_i,
	input wire logic point0_low_input_i,
	input wire logic point1_high_input_i,
	input wire logic sounder_request_i,
	input wire logic freeze_i,
	// observed outputs
	input wire logic done_o,
	input wire logic [CNT_W-1:0] display_value_o,
	input wire logic [1:0] display_point_o,
	input wire logic overload_text_o,
	input wire logic buzzer_o,
	input wire logic autozero_o,
	input wire logic point_pulldown_en_o,
	input wire logic over_range_o,
	input wire logic under_limit_flag_o
);
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (!resetn_i);
	a_probe_text: assert property ($stable(probe_select_i) [*5] |-> overload_text_o == probe_select_i)
		else $error("overload text wrong");
	a_pulldown_mode: assert property ($stable(probe_select_i) [*5] |-> point_pulldown_en_o == !probe_select_i)
		else $error("pulldown enable wrong");
	a_point_decode: assert property ((!probe_select_i && $stable({point1_high_input_i, point0_low_input_i})) [*5]
		|-> display_point_o == {point1_high_input_i, point0_low_input_i})
		else $error("point position wrong");
	a_probe_autozero: assert property ((probe_select_i && !measure_select_i) [*5] |-> autozero_o)
		else $error("not held in autozero");
	a_buzz_half: assert property ($fell(buzzer_o) && sounder_request_i && $past(sounder_request_i, 12)
		|-> $past(buzzer_o, 4) && !$past(buzzer_o, 5))
		else $error("buzzer half period wrong");
	a_done_width: assert property ($fell(done_o) |=> (!done_o) [*8] ##1 !done_o ##1 done_o)
		else $error("done pulse width wrong");
	a_hold_display: assert property (freeze_i [*4] ##1 $fell(done_o) |-> $stable(display_value_o))
		else $error("display changed while held");
	a_over_flag: assert property (!freeze_i [*4] ##1 $fell(done_o) |-> over_range_o == (display_value_o > FULL_SCALE))
		else $error("over flag wrong");
	a_under_flag: assert property (!freeze_i [*4] ##1 $fell(done_o)
		|-> under_limit_flag_o == (display_value_o <= UNDER_LIMIT))
		else $error("under flag wrong");
endmodule
bind mmd_control mmd_control_properties i_props (.*);

// ---- tb/mmd_control_test.sv ----
`timescale 1ns/10ps
module mmd_control_test;
	import mmd_pkg::*;
	logic sys_clk_i = 1'h0, resetn_i, probe_select_i = 1'h0, measure_select_i = 1'h0, rng = 1'h0;
	logic rp_q = 1'h0;
	logic [15:0] rp_n = 16'h0000;
	logic point0_low_input_i = 1'h0, point1_high_input_i = 1'h0, sounder_request_i = 1'h0, hold = 1'h0;
	logic tog = 1'h0, cnt_on = 1'h0, range_or_count_input_i, integ_positive_i, freeze_i;
	logic done_o, done_oe_o, points_off_o, overload_text_o, high_annunciator_o, low_annunciator_o, buzzer_o;
	logic autozero_o, integrate_o, deintegrate_o, point_pulldown_en_o, over_range_o, under_limit_flag_o;
	logic [CNT_W-1:0] display_value_o, keep, ticks = 16'h00C8;
	logic [1:0] display_point_o;
	int error_cnt = 0, n_checks = 0;
	assign range_or_count_input_i = cnt_on ? tog : rng;
	mmd_control i_dut (.*);
	mmd_front_model i_front (.sys_clk_i, .deint_i(deintegrate_o), .done_oe_i(done_oe_o), .ticks_i(ticks),
		.hold_i(hold), .integ_o(integ_positive_i), .freeze_o(freeze_i));
	initial forever #50 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) tog <= ~tog;
	// outside party gates each range flag with the inverted done strobe
	always @(posedge sys_clk_i) begin
		rp_q <= (over_range_o || under_limit_flag_o) && !done_o;
		if ((over_range_o || under_limit_flag_o) && !done_o && !rp_q) rp_n <= rp_n + 16'h0001;
	end
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (exp !== got) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// {probe, measure, range, point1, point0, sounder}
	task automatic set(input logic [5:0] v);
		@(posedge sys_clk_i);
		{probe_select_i, measure_select_i, rng, point1_high_input_i, point0_low_input_i, sounder_request_i} <= v;
		repeat (6) @(posedge sys_clk_i);
		#1;
	endtask
	task automatic buzz(input string nm);
		logic b;
		b = buzzer_o;
		repeat (4) @(posedge sys_clk_i);
		#1;
		chk(nm, !b, buzzer_o);
	endtask
	task automatic wait_done(input int lim);
		int k;
		k = 0;
		while (done_o !== 1'h0 && k < lim) begin
			@(posedge sys_clk_i);
			#1;
			k++;
		end
		chk("done", 1'h0, done_o);
		repeat (12) @(posedge sys_clk_i);
		#1;
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		resetn_i <= 1'h0;
		repeat (10) @(posedge sys_clk_i);
		resetn_i <= 1'h1;
		#1;
		chk("done", 1'h1, done_o);
		set(6'h2C);
		chk("ovl", 1'h1, overload_text_o);
		chk("pts_off", 1'h1, points_off_o);
		chk("high", 1'h1, high_annunciator_o);
		chk("low", 1'h0, low_annunciator_o);
		chk("pulldown", 1'h0, point_pulldown_en_o);
		chk("az", 1'h1, autozero_o);
		chk("int", 1'h0, integrate_o);
		chk("deint", 1'h0, deintegrate_o);
		set(6'h2A);
		chk("low", 1'h1, low_annunciator_o);
		chk("high", 1'h0, high_annunciator_o);
		buzz("probe_buz");
		set(6'h30);
		chk("pts_off", 1'h0, points_off_o);
		for (int i = 0; i < 4; i++) begin
			set({3'h1, i[1:0], 1'h0});
			chk("point", i[1:0], display_point_o);
		end
		chk("pulldown", 1'h1, point_pulldown_en_o);
		chk("ovl", 1'h0, overload_text_o);
		set(6'h05);
		buzz("req_buz");
		set(6'h04);
		wait_done(20000);
		chk("under", 1'h1, under_limit_flag_o);
		chk("over", 1'h0, over_range_o);
		chk("small", 1'h1, display_value_o <= UNDER_LIMIT);
		keep = display_value_o;
		@(posedge sys_clk_i);
		hold <= 1'h1;
		ticks <= 16'hFFFF;
		wait_done(20000);
		chk("held", keep, display_value_o);
		chk("over", 1'h1, over_range_o);
		chk("under", 1'h0, under_limit_flag_o);
		@(posedge sys_clk_i);
		hold <= 1'h0;
		cnt_on <= 1'h1;
		set(6'h10);
		wait_done(45000);
		chk("freq", 1'h1, display_value_o >= 16'h4E1E && display_value_o <= 16'h4E22);
		chk("over", 1'h1, over_range_o);
		chk("range_pulses", 16'h0003, rp_n);
		end_sim;
	end
	initial begin
		repeat (90000) @(posedge sys_clk_i);
		error_cnt++;
		end_sim;
	end
endmodule
